/* include/memmap_pkg.sv */
// Purpose: shared constants for the vector, table read and data memory block
// Assumes: 8-bit data memory, 16-bit program words, single system clock
// Notes:   special area occupies 00H..3FH, general purpose area 40H..FFH per bank
package memmap_pkg;
  // special function register addresses held by this block
  localparam logic [7:0]  IAR_A_ADDR   = 8'h00; // indirect access through pointer a
  localparam logic [7:0]  MP_A_ADDR    = 8'h01; // memory pointer a
  localparam logic [7:0]  IAR_B_ADDR   = 8'h02; // indirect access through pointer b
  localparam logic [7:0]  MP_B_ADDR    = 8'h03; // memory pointer b
  localparam logic [7:0]  BP_ADDR      = 8'h04; // bank pointer
  localparam logic [7:0]  TBLP_ADDR    = 8'h07; // table pointer
  localparam logic [7:0]  TABLE_HIGH_BYTE_ADDR    = 8'h08; // table high byte, read only
  // general purpose area layout
  localparam logic [7:0]  GP_BASE      = 8'h40;  // first general purpose address
  localparam logic [11:0] GP_SIZE      = 12'h0C0; // locations per bank
  localparam logic [3:0]  NUM_BANKS    = 4'hB;   // banks 0 to 10
  localparam int          RAM_DEPTH    = 2112;   // 11 banks of 192 bytes
  // one bit per special address: set where some register answers a read
  localparam logic [63:0] SFR_USED     = 64'hFF3F_FFFF_FFCF_FFFF;
  // access kinds produced by address resolution
  localparam logic [1:0]  KIND_NONE    = 2'h0; // reads 00H, writes dropped
  localparam logic [1:0]  KIND_GP      = 2'h1; // general purpose ram
  localparam logic [1:0]  KIND_SFR     = 2'h2; // special function area
  // reset values
  localparam logic [3:0]  BP_RESET     = 4'h0;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  // interrupt vectors, lowest address wins
  localparam logic [13:0] VEC_PERIPH   = 14'h0010;
  localparam logic [13:0] VEC_RTC      = 14'h0014;
  localparam logic [13:0] VEC_MFI      = 14'h0018;
  localparam int          NUM_IRQ      = 3;
  // edge sense of synchronised pins: bit set means rising edge
  localparam logic [3:0]  PIN_RISE     = 4'h4;
  // table read sequencer
  typedef enum logic [0:0] {
    TBL_IDLE  = 1'b0,
    TBL_FETCH = 1'b1
  } tbl_state_t;
endpackage : memmap_pkg

/* rtl/table_addr.sv */
// Purpose: forms the program memory address of a table read
// Assumes: pointer and page bits are stable while sampled
// Notes:   purely combinational, registered by the caller
`timescale 1ns/10ps
module table_addr #(
  parameter int PROG_AW = 14 // 13 on the small program memory, 14 on the large
) (
  input  wire logic [5:0]         pc_upper,   // current program counter bits 13..8
  input  wire logic [7:0]         tblp,       // table pointer
  input  wire logic               last_page,  // high selects the last page
  output logic      [PROG_AW-1:0] addr        // resulting table address
);
  logic [13:0] full; // address before trimming to the variant width

  // upper bits come from the page, lower bits always from the pointer
  always_comb begin
    if (last_page) begin
      full = {6'h3F, tblp};
    end else begin
      full = {pc_upper, tblp};
    end
  end

  // small variant simply drops bit 13
  assign addr = full[PROG_AW-1:0];
endmodule : table_addr

/* rtl/vector_select.sv */
// Purpose: picks the interrupt to serve and its vector
// Assumes: pending flags and enables come from the same clock domain
// Notes:   combinational; the caller registers the result
`timescale 1ns/10ps
module vector_select (
  input  wire logic [2:0]  pend,       // pending: periph, rtc, multi-function
  input  wire logic [2:0]  enable,     // per source interrupt enables
  input  wire logic        stack_full, // no free return stack level
  output logic             req,        // request towards the cpu
  output logic [13:0]      vector,     // address of the chosen entry
  output logic [2:0]       grant       // one-hot chosen source
);
  logic [2:0] live; // pending and enabled

  assign live = pend & enable;

  // fixed priority, lowest vector address first; stack full holds them back
  always_comb begin
    grant  = 3'h0;
    vector = memmap_pkg::VEC_PERIPH;
    if (live[0]) begin
      grant  = 3'h1;
      vector = memmap_pkg::VEC_PERIPH;
    end else if (live[1]) begin
      grant  = 3'h2;
      vector = memmap_pkg::VEC_RTC;
    end else if (live[2]) begin
      grant  = 3'h4;
      vector = memmap_pkg::VEC_MFI;
    end
    req = (|live) && !stack_full;
  end
endmodule : vector_select

/* rtl/vector_table_and_data_memory.sv */
// Purpose: interrupt vectors, table reads and banked data memory of the core
// Assumes: cpu keeps one data access per cycle and none during a table fetch
// Notes:   read data appears one cycle after the request, table results two cycles after
//
// Behaviour
// - telephony receive events vector to 010H
// - clock time-out vectors to 014H
// - multi-function events vector to 018H
// - table pointer gives address bits 7..0
// - current page uses program counter bits 13..8
// - last page forces upper bits to ones
// - low byte to target, high byte held
// - unused high byte bits are undefined
// - held high byte is read only
// - table read takes two cycles
// - table address 13 or 14 bits
// - byte memory, special area from 00H
// - eleven general banks chosen by bank pointer
// - special registers reachable from any bank
// - unused special addresses read 00H
// - direct bank 0, pointer b reaches others
// - single bit set and clear
// - ram contents undefined until written
// - pointer a always reaches bank 0
// - reset clears bank unless watchdog sleep reset
// - indirect access of indirect ports is void
// - stack full holds request pending
`timescale 1ns/10ps
module vector_table_and_data_memory #(
  parameter int PROG_AW = 14 // program address width of the variant
) (
  input  wire logic               clock,                // system clock
  input  wire logic               rst_b,                // power-on reset
  input  wire logic               soft_reset,           // one-cycle system reset
  input  wire logic               soft_reset_keep_bank, // reset was watchdog in sleep
  input  wire logic               periph_enable,        // tone and fsk receivers on
  input  wire logic [4:0]         periph_events,        // receiver event pulses
  input  wire logic               periph_int_en,        // peripheral interrupt enable
  input  wire logic               rtc_enable,           // real-time clock on
  input  wire logic               rtc_timeout,          // clock time-out pulse
  input  wire logic               rtc_int_en,           // clock interrupt enable
  input  wire logic               port_c_bit0,          // pin, falling edge
  input  wire logic               port_c_bit5,          // pin, falling edge
  input  wire logic               port_c_bit7,          // pin, rising edge
  input  wire logic               ext_periph_pin,       // pin, falling edge
  input  wire logic               serial_int,           // serial interface pulse
  input  wire logic               timer2_overflow,      // third timer pulse
  input  wire logic               mfi_int_en,           // multi-function enable
  input  wire logic               stack_full,           // all stack levels used
  input  wire logic               int_taken,            // cpu took int_vector
  output logic                    int_request,          // interrupt wanted
  output logic      [13:0]        int_vector,           // entry address
  input  wire logic               mem_rd,               // data read request
  input  wire logic               mem_wr,               // data byte write
  input  wire logic               mem_bit_set,          // set one bit
  input  wire logic               mem_bit_clr,          // clear one bit
  input  wire logic [2:0]         mem_bit_idx,          // bit for set or clear
  input  wire logic [7:0]         mem_addr,             // instruction address
  input  wire logic [7:0]         mem_wdata,            // write byte
  input  wire logic [7:0]         ext_sfr_rdata,        // other special registers
  output logic      [7:0]         mem_rdata,            // read byte
  input  wire logic               tbl_start,            // table read request
  input  wire logic               tbl_last_page,        // last page form
  input  wire logic [5:0]         pc_upper,             // program counter 13..8
  input  wire logic [7:0]         tbl_dest,             // target data address
  input  wire logic [15:0]        prog_data,            // program word
  output logic                    prog_rd,              // program memory read
  output logic      [PROG_AW-1:0] prog_addr,            // program memory address
  output logic                    tbl_done,             // table read finished
  output logic      [7:0]         table_high_byte       // held high byte
);
  // data storage and pointers
  logic [7:0]             ram [0:memmap_pkg::RAM_DEPTH-1]; // no reset
  logic [7:0]             mp_a;          // memory pointer a
  logic [7:0]             mp_b;          // memory pointer b
  logic [3:0]             bank_pointer;  // selected bank
  logic [7:0]             tblp;          // table pointer
  // table sequencer
  memmap_pkg::tbl_state_t tbl_state;     // idle or fetching
  logic [7:0]             dest_q;        // target captured at start
  logic [PROG_AW-1:0]     next_prog_addr; // address from the former
  // access path
  logic                   tbl_wr;        // table low byte writes this cycle
  logic                   cpu_wr;        // cpu write or bit op
  logic                   do_wr;         // some write this cycle
  logic [7:0]             wr_addr;       // instruction address of the write
  logic [13:0]            wr_tgt;        // resolved write target
  logic [13:0]            rd_tgt;        // resolved read target
  logic [7:0]             wr_old;        // current byte at write target
  logic [7:0]             wr_new;        // byte to store
  logic [7:0]             rd_byte;       // byte to return
  // interrupt path
  logic [3:0]             pins;          // pins needing synchronising
  logic [3:0]             pin_s1;        // first stage
  logic [3:0]             pin_s2;        // second stage
  logic [3:0]             pin_s3;        // previous second stage
  logic [3:0]             pin_edge;      // qualified edges
  logic [2:0]             warm;          // edges ignored until all three stages fill
  logic [2:0]             pend;          // sticky requests
  logic [2:0]             irq_en;        // enables per source
  logic [2:0]             irq_set;       // new events per source
  logic                   next_req;      // arbiter request
  logic [13:0]            next_vec;      // arbiter vector
  logic [2:0]             next_grant;    // arbiter choice
  logic [2:0]             grant_q;       // choice shown to the cpu

  // maps an address to none, general ram index or special address
  function automatic logic [13:0] resolve(input logic [7:0] a);
    logic [7:0] eff;
    logic [3:0] bank;
    logic       ind;
    eff  = a;
    bank = 4'h0; // direct access stays in bank 0
    ind  = 1'b0;
    if (a == memmap_pkg::IAR_A_ADDR) begin
      eff = mp_a; // bank 0 whatever the bank pointer
      ind = 1'b1;
    end else if (a == memmap_pkg::IAR_B_ADDR) begin
      eff  = mp_b;
      bank = bank_pointer;
      ind  = 1'b1;
    end
    if (ind && (eff == memmap_pkg::IAR_A_ADDR || eff == memmap_pkg::IAR_B_ADDR)) begin
      resolve = {memmap_pkg::KIND_NONE, 12'h000};
    end else if (eff < memmap_pkg::GP_BASE) begin
      resolve = {memmap_pkg::KIND_SFR, 4'h0, eff};
    end else if (bank >= memmap_pkg::NUM_BANKS) begin
      resolve = {memmap_pkg::KIND_NONE, 12'h000};
    end else begin
      resolve = {memmap_pkg::KIND_GP,
                 12'(12'(bank) * memmap_pkg::GP_SIZE + 12'(eff - memmap_pkg::GP_BASE))};
    end
  endfunction : resolve

  // special register read, unused addresses give zero
  function automatic logic [7:0] sfr_read(input logic [7:0] a);
    case (a)
      memmap_pkg::MP_A_ADDR: sfr_read = mp_a;
      memmap_pkg::MP_B_ADDR: sfr_read = mp_b;
      memmap_pkg::BP_ADDR:   sfr_read = {4'h0, bank_pointer};
      memmap_pkg::TBLP_ADDR: sfr_read = tblp;
      memmap_pkg::TABLE_HIGH_BYTE_ADDR: sfr_read = table_high_byte;
      default: begin
        if (memmap_pkg::SFR_USED[a[5:0]]) begin
          sfr_read = ext_sfr_rdata;
        end else begin
          sfr_read = 8'h00;
        end
      end
    endcase
  endfunction : sfr_read

  // table address former
  table_addr #(
    .PROG_AW   (PROG_AW)
  ) u_table_addr (
    .pc_upper  (pc_upper),
    .tblp      (tblp),
    .last_page (tbl_last_page),
    .addr      (next_prog_addr)
  );

  // write path: the table result has the port while a fetch ends
  always_comb begin
    tbl_wr  = (tbl_state == memmap_pkg::TBL_FETCH);
    cpu_wr  = (mem_wr || mem_bit_set || mem_bit_clr) && !tbl_wr;
    do_wr   = tbl_wr || cpu_wr;
    wr_addr = tbl_wr ? dest_q : mem_addr;
    wr_tgt  = resolve(wr_addr);
    rd_tgt  = resolve(mem_addr);
    wr_old  = 8'h00;
    if (wr_tgt[13:12] == memmap_pkg::KIND_GP) begin
      wr_old = ram[wr_tgt[11:0]];
    end else if (wr_tgt[13:12] == memmap_pkg::KIND_SFR) begin
      wr_old = sfr_read(wr_tgt[7:0]);
    end
    if (tbl_wr) begin
      wr_new = prog_data[7:0];
    end else if (mem_bit_set) begin
      wr_new = wr_old | (8'h01 << mem_bit_idx);
    end else if (mem_bit_clr) begin
      wr_new = wr_old & ~(8'h01 << mem_bit_idx);
    end else begin
      wr_new = mem_wdata;
    end
    rd_byte = 8'h00;
    if (rd_tgt[13:12] == memmap_pkg::KIND_GP) begin
      rd_byte = ram[rd_tgt[11:0]];
    end else if (rd_tgt[13:12] == memmap_pkg::KIND_SFR) begin
      rd_byte = sfr_read(rd_tgt[7:0]);
    end
  end

  // general purpose ram, left uninitialised on purpose to save reset logic
  always_ff @(posedge clock) begin
    if (do_wr && wr_tgt[13:12] == memmap_pkg::KIND_GP) begin
      ram[wr_tgt[11:0]] <= wr_new;
    end
  end

  // pointer registers; the held high byte is not among them
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mp_a <= memmap_pkg::BYTE_RESET;
      mp_b <= memmap_pkg::BYTE_RESET;
      tblp <= memmap_pkg::BYTE_RESET;
    end else if (do_wr && wr_tgt[13:12] == memmap_pkg::KIND_SFR) begin
      case (wr_tgt[7:0])
        memmap_pkg::MP_A_ADDR: mp_a <= wr_new;
        memmap_pkg::MP_B_ADDR: mp_b <= wr_new;
        memmap_pkg::TBLP_ADDR: tblp <= wr_new;
        default: ;
      endcase
    end
  end

  // bank pointer; a watchdog wake reset keeps the selected bank
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bank_pointer <= memmap_pkg::BP_RESET;
    end else if (soft_reset) begin
      if (!soft_reset_keep_bank) begin
        bank_pointer <= memmap_pkg::BP_RESET;
      end
    end else if (do_wr && wr_tgt == {memmap_pkg::KIND_SFR, 4'h0, memmap_pkg::BP_ADDR}) begin
      bank_pointer <= wr_new[3:0];
    end
  end

  // read data, one cycle after the request
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mem_rdata <= memmap_pkg::BYTE_RESET;
    end else if (mem_rd) begin
      mem_rdata <= rd_byte;
    end
  end

  // table sequencer: address out on the first edge, result on the second
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tbl_state <= memmap_pkg::TBL_IDLE;
      dest_q    <= memmap_pkg::BYTE_RESET;
      prog_addr <= '0;
      prog_rd   <= 1'b0;
      tbl_done  <= 1'b0;
    end else begin
      tbl_done <= 1'b0;
      unique case (tbl_state)
        memmap_pkg::TBL_IDLE: begin
          if (tbl_start) begin
            prog_addr <= next_prog_addr;
            dest_q    <= tbl_dest;
            prog_rd   <= 1'b1;
            tbl_state <= memmap_pkg::TBL_FETCH;
          end
        end
        memmap_pkg::TBL_FETCH: begin
          prog_rd   <= 1'b0;
          tbl_done  <= 1'b1;
          tbl_state <= memmap_pkg::TBL_IDLE;
        end
      endcase
    end
  end

  // held high byte: only a finishing table read loads it, software cannot
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      table_high_byte <= memmap_pkg::BYTE_RESET;
    end else if (tbl_wr) begin
      table_high_byte <= prog_data[15:8];
    end
  end

  // pin synchronisers; edges are judged on stages two and three only
  assign pins = {ext_periph_pin, port_c_bit7, port_c_bit5, port_c_bit0};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
        end else begin
          pin_s1[gi] <= pins[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
        end
      end
      // rising or falling as the pin requires
      assign pin_edge[gi] = warm[2] && (memmap_pkg::PIN_RISE[gi] ?
                            (pin_s2[gi] && !pin_s3[gi]) : (!pin_s2[gi] && pin_s3[gi]));
    end
  endgenerate

  // stops a pin that is high at reset release from looking like an edge;
  // stage three is loaded only on the third edge, so two edges are not enough
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      warm <= 3'h0;
    end else begin
      warm <= {warm[1:0], 1'b1};
    end
  end

  // event collection per vector
  always_comb begin
    irq_set[0] = periph_enable && (|periph_events);
    irq_set[1] = rtc_enable && rtc_timeout;
    irq_set[2] = (|pin_edge) || serial_int || timer2_overflow;
    irq_en     = {mfi_int_en, rtc_int_en, periph_int_en};
  end

  // sticky requests; a new event beats the clear of the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend <= 3'h0;
    end else begin
      pend <= (pend & ~({3{int_taken}} & grant_q)) | irq_set;
    end
  end

  // arbiter
  vector_select u_vector_select (
    .pend       (pend),
    .enable     (irq_en),
    .stack_full (stack_full),
    .req        (next_req),
    .vector     (next_vec),
    .grant      (next_grant)
  );

  // registered request towards the cpu
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      int_request <= 1'b0;
      int_vector  <= memmap_pkg::VEC_PERIPH;
      grant_q     <= 3'h0;
    end else begin
      int_request <= next_req && !int_taken;
      int_vector  <= next_vec;
      grant_q     <= next_grant;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_periph_vec;
    (pend[0] && periph_int_en && !stack_full && !int_taken) |=>
      (int_request && int_vector == memmap_pkg::VEC_PERIPH);
  endproperty
  a_periph_vec: assert property (p_periph_vec) else $error("peripheral vector wrong");

  property p_rtc_vec;
    (pend[1] && rtc_int_en && !(pend[0] && periph_int_en)) |=>
      (int_vector == memmap_pkg::VEC_RTC);
  endproperty
  a_rtc_vec: assert property (p_rtc_vec) else $error("clock vector wrong");

  property p_mfi_vec;
    (pend[2] && mfi_int_en && (pend[1:0] & irq_en[1:0]) == 2'h0) |=>
      (int_vector == memmap_pkg::VEC_MFI);
  endproperty
  a_mfi_vec: assert property (p_mfi_vec) else $error("multi-function vector wrong");

  property p_stack_hold;
    (stack_full && pend[0] && !int_taken) |=> (!int_request && pend[0]);
  endproperty
  a_stack_hold: assert property (p_stack_hold) else $error("request passed full stack");

  property p_cur_page;
    (tbl_start && !tbl_last_page && tbl_state == memmap_pkg::TBL_IDLE) |=>
      (prog_rd && prog_addr == PROG_AW'({$past(pc_upper), $past(tblp)}));
  endproperty
  a_cur_page: assert property (p_cur_page) else $error("current page address wrong");

  property p_last_page;
    (tbl_start && tbl_last_page && tbl_state == memmap_pkg::TBL_IDLE) |=>
      (prog_addr[7:0] == $past(tblp) && (&prog_addr[PROG_AW-1:8]));
  endproperty
  a_last_page: assert property (p_last_page) else $error("last page address wrong");

  property p_two_cycles;
    (tbl_start && tbl_state == memmap_pkg::TBL_IDLE) |-> ##1 !tbl_done ##1 tbl_done;
  endproperty
  a_two_cycles: assert property (p_two_cycles) else $error("table read length wrong");

  property p_high_byte;
    tbl_done |-> (table_high_byte == $past(prog_data[15:8]));
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("high byte not held");

  property p_table_high_byte_ro;
    (mem_wr && mem_addr == memmap_pkg::TABLE_HIGH_BYTE_ADDR && !tbl_wr) |=> $stable(table_high_byte);
  endproperty
  a_table_high_byte_ro: assert property (p_table_high_byte_ro) else $error("high byte written by software");

  property p_unused_zero;
    (mem_rd && !memmap_pkg::SFR_USED[mem_addr[5:0]] && mem_addr < memmap_pkg::GP_BASE) |=>
      (mem_rdata == 8'h00);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused address not zero");

  property p_bank_reset;
    (soft_reset && !soft_reset_keep_bank) |=> (bank_pointer == memmap_pkg::BP_RESET);
  endproperty
  a_bank_reset: assert property (p_bank_reset) else $error("bank not cleared by reset");
endmodule : vector_table_and_data_memory

/* tb/prog_mem_model.sv */
// Purpose: program memory seen by table reads
// Assumes: word must be valid only while prog_rd is high
// Notes:   idle bus toggles every cycle so a stale word is never mistaken for a fresh one
`timescale 1ns/10ps
module prog_mem_model (
  input  wire logic        clock,     // system clock
  input  wire logic        prog_rd,   // read strobe from the block
  input  wire logic [13:0] prog_addr, // word address
  output logic      [15:0] prog_data  // high byte is the inverted low address
);
  logic [15:0] junk = 16'h5A3C; // idle pattern
  // advance the idle pattern each cycle
  always @(posedge clock) begin
    junk <= ~junk + 16'h0001;
  end
  assign prog_data = prog_rd ? {~prog_addr[7:0], prog_addr[7:0]} : junk;
endmodule : prog_mem_model

/* tb/tb_vector_table_and_data_memory.sv */
// Purpose: self-checking bench for vectors, table reads and banked data memory
// Assumes: inputs change at the falling edge, results come from a queue of expectations
// Notes:   one watcher pops the oldest expectation whenever a result shows
`timescale 1ns/10ps
module tb_vector_table_and_data_memory;
  logic clock = 0, rst_b = 0, soft_reset = 0, soft_reset_keep_bank = 0, periph_enable = 1;
  logic periph_int_en = 1, rtc_enable = 1, rtc_timeout = 0, rtc_int_en = 1, mfi_int_en = 1;
  logic stack_full = 0, int_taken = 0, port_c_bit0 = 1, port_c_bit5 = 1, port_c_bit7 = 0;
  logic ext_periph_pin = 1, serial_int = 0, timer2_overflow = 0, tbl_start = 0;
  logic mem_rd = 0, mem_wr = 0, mem_bit_set = 0, mem_bit_clr = 0, tbl_last_page = 0;
  logic [4:0]  periph_events = 0;
  logic [2:0]  mem_bit_idx = 0;
  logic [5:0]  pc_upper = 0;
  logic [7:0]  mem_addr = 0, mem_wdata = 0, ext_sfr_rdata = 0, tbl_dest = 0, v, m;
  logic [7:0]  mem_rdata, table_high_byte;
  logic [15:0] prog_data, exp_q[$];
  logic [13:0] int_vector, prog_addr;
  logic        int_request, prog_rd, tbl_done, rd_d = 0, int_d = 0;
  int          errors = 0, check_count = 0, cyc = 0;
  vector_table_and_data_memory vector_table_and_data_memory_inst (.*);
  prog_mem_model prog_mem_model_inst (.*);
  initial forever #50 clock = ~clock;
  task check(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %0t got %h want %h", $time, s, e);
    end
  endtask : check
  // one data access: request held over exactly one rising edge
  task acc(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    {mem_rd, mem_wr, mem_bit_set, mem_bit_clr} = k;
    mem_addr = a;
    mem_wdata = d;
    mem_bit_idx = d[2:0];
    @(negedge clock);
    {mem_rd, mem_wr, mem_bit_set, mem_bit_clr} = 4'h0;
  endtask : acc
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({8'h00, e});
    acc(4'h8, a, 8'h00);
  endtask : rd
  task tbl(input logic lp, input logic [5:0] pc, input logic [7:0] tp);
    acc(4'h4, memmap_pkg::TBLP_ADDR, tp);
    exp_q.push_back({2'b00, (lp ? 6'h3F : pc), tp});
    exp_q.push_back({8'h00, ~tp});
    @(negedge clock);
    {tbl_start, tbl_last_page, pc_upper, tbl_dest} = {1'b1, lp, pc, 8'h41};
    @(negedge clock);
    tbl_start = 0;
    @(negedge clock);
    rd(8'h41, tp);
    acc(4'h4, memmap_pkg::TABLE_HIGH_BYTE_ADDR, tp);
    rd(memmap_pkg::TABLE_HIGH_BYTE_ADDR, ~tp);
  endtask : tbl
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // remember last cycle's read strobe and request level
  always @(posedge clock) begin
    rd_d <= mem_rd;
    int_d <= int_request;
    cyc++;
    if (cyc == 3000) begin
      errors++;
      complete_run;
    end
  end
  // watcher: each visible result consumes the oldest expectation
  always @(negedge clock) begin
    if (rd_d) check(mem_rdata, exp_q.pop_front());
    if (prog_rd) check(prog_addr, exp_q.pop_front());
    if (tbl_done) check(table_high_byte, exp_q.pop_front());
    if (int_request && !int_d) check(int_vector, exp_q.pop_front());
  end
  initial begin
    v = $urandom(61);
    v = $urandom;
    m = (v | 8'h08) & ~8'h20;
    repeat (6) @(negedge clock);
    rst_b = 1;
    acc(4'h4, 8'h40, v);
    acc(4'h2, 8'h40, 8'h03);
    acc(4'h1, 8'h40, 8'h05);
    rd(8'h40, m);
    acc(4'h4, memmap_pkg::BP_ADDR, 8'h02);
    acc(4'h4, memmap_pkg::MP_B_ADDR, 8'h40);
    acc(4'h4, memmap_pkg::IAR_B_ADDR, ~v);
    acc(4'h4, memmap_pkg::MP_A_ADDR, 8'h40);
    rd(memmap_pkg::IAR_B_ADDR, ~v);
    rd(memmap_pkg::IAR_A_ADDR, m);
    rd(8'h40, m);
    rd(memmap_pkg::BP_ADDR, 8'h02);
    rd(8'h14, 8'h00);
    ext_sfr_rdata = v;
    rd(8'h05, v);
    acc(4'h4, memmap_pkg::MP_B_ADDR, memmap_pkg::IAR_B_ADDR);
    rd(memmap_pkg::IAR_B_ADDR, 8'h00);
    for (int k = 0; k < 2; k++) begin
      soft_reset_keep_bank = (k == 0);
      @(negedge clock);
      soft_reset = 1;
      @(negedge clock);
      soft_reset = 0;
      rd(memmap_pkg::BP_ADDR, k ? 8'h00 : 8'h02);
    end
    $display("data memory test done");
    tbl(1'b0, v[5:0], v);
    tbl(1'b1, ~v[5:0], ~v);
    $display("table read test done");
    {periph_enable, rtc_enable} = 2'h0;
    {periph_events, rtc_timeout} = 6'h3F;
    @(negedge clock);
    {periph_enable, rtc_enable, periph_events, rtc_timeout} = 8'hC0;
    repeat (3) @(negedge clock);
    check(int_request, 16'h0000);
    stack_full = 1;
    @(negedge clock);
    {periph_events, rtc_timeout, serial_int, timer2_overflow} = {v[4:0] | 5'h01, 3'h7};
    {port_c_bit0, port_c_bit5, port_c_bit7, ext_periph_pin} = 4'h2;
    @(negedge clock);
    {periph_events, rtc_timeout, serial_int, timer2_overflow} = 8'h00;
    repeat (5) @(negedge clock);
    check(int_request, 16'h0000);
    exp_q.push_back({2'b00, memmap_pkg::VEC_PERIPH});
    exp_q.push_back({2'b00, memmap_pkg::VEC_RTC});
    exp_q.push_back({2'b00, memmap_pkg::VEC_MFI});
    stack_full = 0;
    repeat (3) begin
      for (int n = 0; n < 20 && int_request !== 1'b1; n++) @(negedge clock);
      int_taken = 1;
      @(negedge clock);
      int_taken = 0;
      @(negedge clock);
    end
    {port_c_bit0, port_c_bit5, port_c_bit7, ext_periph_pin} = 4'hD;
    repeat (6) @(negedge clock);
    check(int_request, 16'h0000);
    exp_q.push_back({2'b00, memmap_pkg::VEC_MFI});
    port_c_bit7 = 1;
    for (int n = 0; n < 20 && int_request !== 1'b1; n++) @(negedge clock);
    int_taken = 1;
    @(negedge clock);
    int_taken = 0;
    repeat (2) @(negedge clock);
    check(exp_q.size(), 16'h0000);
    $display("interrupt test done");
    complete_run;
  end
endmodule : tb_vector_table_and_data_memory
